//--- rtl/pcsbc_cfg.svh
// pcsbc_cfg.svh: offsets, field positions, reset values and fixed words
// assumes inclusion by the package and the block; definitions only
`ifndef PCSBC_CFG_SVH
`define PCSBC_CFG_SVH
// register word indexes; byte address is four times the index
`define PCSBC_IDX_CTRL 4'h0
`define PCSBC_IDX_ADV 4'h1
`define PCSBC_IDX_MODE 4'h2
`define PCSBC_IDX_LINK_IN 4'h3
`define PCSBC_IDX_STATUS 4'h4
`define PCSBC_IDX_EFFECT 4'h5
`define PCSBC_IDX_ADV_USED 4'h6
// control word bit positions
`define PCSBC_CTL_UNIDIR 0
`define PCSBC_CTL_LOOP 1
`define PCSBC_CTL_PDOWN 2
`define PCSBC_CTL_ISOLATE 3
`define PCSBC_CTL_AN_EN 4
// mode word bit positions
`define PCSBC_MODE_SGMII 0
`define PCSBC_MODE_PHY_SIDE 1
`define PCSBC_MODE_TBI 2
`define PCSBC_MODE_AN_BUILT 3
// link input word bit positions
`define PCSBC_LIN_SYNC_OK 0
`define PCSBC_LIN_AN_DONE 1
`define PCSBC_LIN_XCVR_DONE 2
`define PCSBC_LIN_XCVR_USED 3
// advertisement field positions
`define PCSBC_ADV_SGMII_ONE 0
`define PCSBC_ADV_FDX 5
`define PCSBC_ADV_PAUSE_HI 8
`define PCSBC_ADV_PAUSE_LO 7
`define PCSBC_ADV_SPEED_HI 11
`define PCSBC_ADV_SPEED_LO 10
`define PCSBC_ADV_RFLT_HI 13
`define PCSBC_ADV_RFLT_LO 12
`define PCSBC_ADV_SDPX 12
`define PCSBC_ADV_ACK 14
`define PCSBC_ADV_LINK 15
// fixed word used by the mac side, and masks of meaningful bits
`define PCSBC_ADV_MAC_FIXED 16'h4001
`define PCSBC_ADV_MASK_BASEX 16'h31A0
`define PCSBC_ADV_MASK_SGMII 16'hDC01
// reset values
`define PCSBC_CTRL_RST 5'h00
`define PCSBC_ADV_RST 16'h0000
`define PCSBC_MODE_RST 4'h0
`define PCSBC_LIN_RST 4'h0
`endif

//--- rtl/pcsbc_pkg.sv
// pcsbc_pkg: types of the side-band configuration and status block
// assumes pcsbc_cfg.svh on the include path
`include "pcsbc_cfg.svh"
package pcsbc_pkg;
  // register bus request from software
  typedef struct packed {
    logic [3:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } pcsbc_bus_t;
  // effect outputs toward the datapath
  typedef struct packed {
    logic tx_force_en;
    logic loopback;
    logic xcvr_pdown;
    logic gmii_isolate;
    logic an_enable;
  } pcsbc_ctl_t;
  // status bundle, bits 1:0
  typedef struct packed {
    logic sync_ok;
    logic link_up;
  } pcsbc_stat_t;
endpackage : pcsbc_pkg

//--- rtl/pcsbc_top.sv
// pcsbc_top: side-band configuration, advertisement and status bundles
// assumes one core clock, software on a plain strobe port, and that
// the datapath raw states arrive from other clock domains via pins
// limitation: power-down stays latched until reset, whatever the bit does later
// limitation: reserved advertisement bits read as zero in the word in use
//
// Contract
// - Unidirectional bit 1 forces transmitter enable; 0 means normal operation.
// - Power-down bit with transceiver sleeps it; only reset clears.
// - Ten-bit interface variant ignores the power-down bit entirely.
// - Isolate bit 1 isolates client GMII; 0 resumes normal operation.
// - Auto-negotiation bit enables negotiation only when built in.
// - Base-X: advertisement bit 5 advertises full duplex; reserved in SGMII.
// - Base-X: bits 8:7 encode pause ability; reserved in SGMII.
// - SGMII: bits 11:10 encode speed; reserved in base-X.
// - Base-X: bits 13:12 encode remote fault.
// - SGMII: bit 12 is duplex, bit 13 reserved.
// - SGMII: bit 14 is acknowledge; reserved in base-X.
// - SGMII: bit 15 is PHY link state; reserved otherwise.
// - SGMII MAC side uses a fixed word, ignoring the bundle.
// - Base-X and SGMII PHY side load the word from the bundle.
// - Link up needs sync, finished negotiation, finished transceiver reset.
// - Link low whenever sync fails or enabled negotiation unfinished.
// - Negotiation on: link equals link status; off: equals sync. The code with negotiation off gives sync and finished transceiver reset.
// - Sync bit follows sync state only, independent of negotiation.
`include "pcsbc_cfg.svh"
module pcsbc_top (
  input wire logic i_clk_sys,
  input wire logic i_arst_n,
  input wire pcsbc_pkg::pcsbc_bus_t i_bus,
  input wire logic i_sync_ok_raw,
  input wire logic i_an_done_raw,
  input wire logic i_xcvr_done_raw,
  output logic [31:0] o_rdata,
  output pcsbc_pkg::pcsbc_ctl_t o_ctl,
  output pcsbc_pkg::pcsbc_stat_t o_stat,
  output logic [15:0] o_advert_word,
  output logic o_sgmii_mode
);
  import pcsbc_pkg::*;

  // software register map, word index on the strobe port:
  //   0 control bundle: unidirectional, loopback, power-down, isolate, negotiation
  //   1 advertisement bundle as the client programs it
  //   2 mode straps: sgmii, phy side, ten-bit variant, negotiation built
  //   3 link inputs: sync, negotiation done, transceiver done, transceiver used
  //   4 status bundle, read only
  //   5 effect bundle, read only
  //   6 advertisement word in use, read only
  //   other indexes read zero and ignore writes

  // software-held bundles and mode straps
  logic [4:0] ctrl;
  logic [15:0] advert_bundle;
  logic [3:0] mode;
  logic [3:0] link_in;
  logic pdown_latch;
  // synchronisers for the raw datapath states
  logic [2:0] raw_meta;
  logic [2:0] raw_sync;
  // decoded modes and derived terms
  logic sgmii;
  logic mac_side;
  logic an_active;
  logic sync_ok;
  logic an_done;
  logic xcvr_done;
  logic [15:0] next_advert;
  logic next_link_up;
  logic [31:0] next_rdata;
  logic pdown_req;
  logic xcvr_used;
  logic tbi_variant;
  logic an_gate;
  logic [15:0] adv_basex;
  logic [15:0] adv_sgmii;
  // write strobes per register
  logic wr_ctrl;
  logic wr_adv;
  logic wr_mode;
  logic wr_link;

  // per-concern effect and status flops, gathered into the output bundles
  logic tx_force;
  logic loop_en;
  logic pdown_out;
  logic isolate;
  logic an_on;
  logic stat_sync;
  logic stat_link;
  // raw pin states gathered for the synchroniser loop
  logic [2:0] raw_pins;

  // write decode used for every writable register
  function automatic logic wr_hit(input pcsbc_bus_t b, input logic [3:0] idx);
    wr_hit = b.wr && (b.addr == idx);
  endfunction : wr_hit

  // keep only bits that carry meaning in the active standard
  function automatic logic [15:0] adv_filter(input logic [15:0] w, input logic sg);
    adv_filter = sg ? (w & `PCSBC_ADV_MASK_SGMII) : (w & `PCSBC_ADV_MASK_BASEX);
  endfunction : adv_filter

  // write strobes per register
  assign wr_ctrl = wr_hit(i_bus, `PCSBC_IDX_CTRL);
  assign wr_adv = wr_hit(i_bus, `PCSBC_IDX_ADV);
  assign wr_mode = wr_hit(i_bus, `PCSBC_IDX_MODE);
  assign wr_link = wr_hit(i_bus, `PCSBC_IDX_LINK_IN);

  // control bundle register
  // written whole; bits above 4 are dropped
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ctrl <= `PCSBC_CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl <= i_bus.wdata[4:0];
    end
  end

  // advertisement bundle register
  // kept raw; masking happens only on the word in use
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      advert_bundle <= `PCSBC_ADV_RST;
    end else if (wr_adv) begin
      advert_bundle <= i_bus.wdata[15:0];
    end
  end

  // mode straps: standard, side, interface variant, negotiation built
  // may change at any time; the word in use follows one edge later
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      mode <= `PCSBC_MODE_RST;
    end else if (wr_mode) begin
      mode <= i_bus.wdata[3:0];
    end
  end

  // software view of link inputs, ored with synchronised pins
  // a set bit cannot be cleared by its pin, only by software
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      link_in <= `PCSBC_LIN_RST;
    end else if (wr_link) begin
      link_in <= i_bus.wdata[3:0];
    end
  end

  // raw pins in bit order of the link input word
  assign raw_pins = {i_xcvr_done_raw, i_an_done_raw, i_sync_ok_raw};

  // two-flop synchroniser per raw pin; only the second stage is read
  // first stage may go metastable, so nothing else looks at it
  for (genvar g = 0; g < 3; g++) begin : g_pin_sync
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
        raw_meta[g] <= 1'b0;
        raw_sync[g] <= 1'b0;
      end else begin
        raw_meta[g] <= raw_pins[g];
        raw_sync[g] <= raw_meta[g];
      end
    end
  end

  // decoded standard and side
  assign sgmii = mode[`PCSBC_MODE_SGMII];
  assign mac_side = sgmii && !mode[`PCSBC_MODE_PHY_SIDE];
  assign tbi_variant = mode[`PCSBC_MODE_TBI];

  // negotiation counts only where it was built in
  assign an_active = ctrl[`PCSBC_CTL_AN_EN] && mode[`PCSBC_MODE_AN_BUILT];

  // link terms: synchronised pins ored with the software view
  assign sync_ok = raw_sync[0] | link_in[`PCSBC_LIN_SYNC_OK];
  assign an_done = raw_sync[1] | link_in[`PCSBC_LIN_AN_DONE];
  assign xcvr_used = link_in[`PCSBC_LIN_XCVR_USED];
  // transceiver reset counts as done where no transceiver is used
  assign xcvr_done = raw_sync[2] | link_in[`PCSBC_LIN_XCVR_DONE] | !xcvr_used;

  // power-down request: bit set, transceiver in use, not the ten-bit variant
  assign pdown_req = ctrl[`PCSBC_CTL_PDOWN] && xcvr_used && !tbi_variant;

  // power-down latch: set by the bit, cleared only by reset
  // a sleeping transceiver must not wake on a bit clear
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pdown_latch <= 1'b0;
    end else if (pdown_req) begin
      pdown_latch <= 1'b1;
    end
  end

  // effect outputs toward the datapath, one flop per concern

  // transmitter forced on regardless of receive state
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      tx_force <= 1'b0;
    end else begin
      tx_force <= ctrl[`PCSBC_CTL_UNIDIR];
    end
  end

  // loopback request passed through
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      loop_en <= 1'b0;
    end else begin
      loop_en <= ctrl[`PCSBC_CTL_LOOP];
    end
  end

  // transceiver sleep from the sticky latch
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pdown_out <= 1'b0;
    end else begin
      pdown_out <= pdown_latch;
    end
  end

  // client interface isolation
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      isolate <= 1'b0;
    end else begin
      isolate <= ctrl[`PCSBC_CTL_ISOLATE];
    end
  end

  // negotiation enable, only where built in
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      an_on <= 1'b0;
    end else begin
      an_on <= an_active;
    end
  end

  // effect bundle gathered straight from the flops above
  assign o_ctl.tx_force_en = tx_force;
  assign o_ctl.loopback = loop_en;
  assign o_ctl.xcvr_pdown = pdown_out;
  assign o_ctl.gmii_isolate = isolate;
  assign o_ctl.an_enable = an_on;

  // base-x candidate keeps 5, 8:7 and 13:12
  assign adv_basex = adv_filter(advert_bundle, 1'b0);

  // sgmii phy side candidate keeps 0, 11:10, 12, 14 and 15
  assign adv_sgmii = adv_filter(advert_bundle, 1'b1);

  // advertisement word selection by standard and side
  always_comb begin
    if (mac_side) begin
      next_advert = `PCSBC_ADV_MAC_FIXED;
    end else if (sgmii) begin
      next_advert = adv_sgmii;
    end else begin
      next_advert = adv_basex;
    end
  end

  // advertisement word in use
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_advert_word <= `PCSBC_ADV_RST;
    end else begin
      o_advert_word <= next_advert;
    end
  end

  // standard flag, aligned with the word in use
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_sgmii_mode <= 1'b0;
    end else begin
      o_sgmii_mode <= sgmii;
    end
  end

  // negotiation gate: open when negotiation is off or has finished
  always_comb begin
    an_gate = !an_active || an_done;
  end

  // link status: sync, negotiation gate, transceiver reset
  always_comb begin
    next_link_up = sync_ok && xcvr_done && an_gate;
  end

  // sync status, independent of negotiation
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      stat_sync <= 1'b0;
    end else begin
      stat_sync <= sync_ok;
    end
  end

  // link status
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      stat_link <= 1'b0;
    end else begin
      stat_link <= next_link_up;
    end
  end

  // status bundle gathered straight from the flops above
  assign o_stat.sync_ok = stat_sync;
  assign o_stat.link_up = stat_link;

  // read mux, unmapped addresses read zero
  // read-only words show the output flops, not their next values
  always_comb begin
    next_rdata = 32'h0000_0000;
    unique case (i_bus.addr)
      `PCSBC_IDX_CTRL: next_rdata = {27'h0, ctrl};
      `PCSBC_IDX_ADV: next_rdata = {16'h0, advert_bundle};
      `PCSBC_IDX_MODE: next_rdata = {28'h0, mode};
      `PCSBC_IDX_LINK_IN: next_rdata = {28'h0, link_in};
      `PCSBC_IDX_STATUS: next_rdata = {30'h0, o_stat};
      `PCSBC_IDX_EFFECT: next_rdata = {27'h0, o_ctl};
      `PCSBC_IDX_ADV_USED: next_rdata = {16'h0, o_advert_word};
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  // read data stands one cycle after the strobe only
  // zero otherwise, so a stale word is never mistaken for an answer
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_rdata <= 32'h0000_0000;
    end else if (i_bus.rd) begin
      o_rdata <= next_rdata;
    end else begin
      o_rdata <= 32'h0000_0000;
    end
  end
endmodule : pcsbc_top

//--- testbench/pcsbc_client.sv
// pcsbc_client: client model driving the raw link state levels
// assumes the bench sets wanted levels just after a core edge
module pcsbc_client (
  input wire logic i_clk_sys,
  input wire logic [2:0] i_lvl,
  output logic [2:0] o_lvl
);
  timeunit 1ns;
  timeprecision 1ns;
  // levels known from time zero
  initial o_lvl = 3'h0;
  // levels move only on a core edge
  always @(posedge i_clk_sys) begin
    o_lvl <= i_lvl;
  end
endmodule : pcsbc_client

//--- testbench/pcsbc_props.sv
// pcsbc_props: port checks of the side-band block
// assumes binding into pcsbc_top, one clock, async reset
module pcsbc_props (
  input wire logic i_clk_sys,
  input wire logic i_arst_n,
  input wire pcsbc_pkg::pcsbc_bus_t i_bus,
  input wire logic [31:0] o_rdata,
  input wire pcsbc_pkg::pcsbc_ctl_t o_ctl,
  input wire pcsbc_pkg::pcsbc_stat_t o_stat,
  input wire logic [15:0] o_advert_word,
  input wire logic o_sgmii_mode
);
  import pcsbc_pkg::*;
  default clocking @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_arst_n);
  // bus answers
  rd_idle_a: assert property (!$past(i_bus.rd) |-> o_rdata == 32'h0)
    else $error("read data without read");
  rd_unmapped_a: assert property (i_bus.rd && i_bus.addr > 4'h6 |=> o_rdata == 32'h0)
    else $error("unmapped read not zero");
  stat_read_a: assert property (i_bus.rd && i_bus.addr == 4'h4
    |=> o_rdata == {30'h0, $past(o_stat)}) else $error("status read wrong");
  ctl_write_a: assert property (i_bus.wr && i_bus.addr == 4'h0 |-> ##2
    {o_ctl.tx_force_en, o_ctl.gmii_isolate} == $past({i_bus.wdata[0], i_bus.wdata[3]}, 2))
    else $error("control effect wrong");
  // advertisement reserved bits stay clear
  basex_mask_a: assert property (!o_sgmii_mode |-> (o_advert_word & 16'hCE5F) == 16'h0)
    else $error("base-x reserved bits set");
  sgmii_mask_a: assert property (o_sgmii_mode |-> (o_advert_word & 16'h23FE) == 16'h0)
    else $error("sgmii reserved bits set");
  // status and sticky power-down
  link_sync_a: assert property (o_stat.link_up |-> o_stat.sync_ok)
    else $error("link up without sync");
  pdown_hold_a: assert property (o_ctl.xcvr_pdown |=> o_ctl.xcvr_pdown)
    else $error("power-down cleared");
  c_link: cover property ($rose(o_stat.link_up));
  c_pdown: cover property ($rose(o_ctl.xcvr_pdown));
  c_mac: cover property (o_sgmii_mode && o_advert_word == 16'h4001);
endmodule : pcsbc_props
bind pcsbc_top pcsbc_props u_props (.i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n), .i_bus(i_bus),
  .o_rdata(o_rdata), .o_ctl(o_ctl), .o_stat(o_stat), .o_advert_word(o_advert_word),
  .o_sgmii_mode(o_sgmii_mode));

//--- testbench/pcsbc_bench.sv
// pcsbc_bench: self-checking bench of the side-band block
// assumes the design under rtl/ and the client model beside it
module pcsbc_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import pcsbc_pkg::*;
  logic i_clk_sys = 1'b0;
  logic i_arst_n = 1'b0;
  pcsbc_bus_t i_bus = '0;
  logic [2:0] lvl = 3'h0;
  logic [2:0] raw;
  logic [31:0] o_rdata;
  pcsbc_ctl_t o_ctl;
  pcsbc_stat_t o_stat;
  logic [15:0] o_advert_word;
  logic o_sgmii_mode;
  int miscompares = 0;
  int comparisons = 0;
  // 25 MHz core clock
  initial begin
    forever #20 i_clk_sys = ~i_clk_sys;
  end
  pcsbc_client u_client (.i_clk_sys(i_clk_sys), .i_lvl(lvl), .o_lvl(raw));
  pcsbc_top DUT (.i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n), .i_bus(i_bus),
    .i_sync_ok_raw(raw[2]), .i_an_done_raw(raw[1]), .i_xcvr_done_raw(raw[0]),
    .o_rdata(o_rdata), .o_ctl(o_ctl), .o_stat(o_stat), .o_advert_word(o_advert_word),
    .o_sgmii_mode(o_sgmii_mode));
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      miscompares++;
      $display("Error %0t: saw %h want %h", $time, s, e);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge i_clk_sys);
    i_bus <= '{a, d, 1'b1, 1'b0};
    @(posedge i_clk_sys);
    i_bus <= '0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge i_clk_sys);
    i_bus <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge i_clk_sys);
    i_bus <= '0;
    #1;
    chk(o_rdata, e);
  endtask : rd
  // let synchronisers and output flops land
  task automatic st();
    repeat (6) @(posedge i_clk_sys);
    #1;
  endtask : st
  task automatic t_ctl();
    wr(4'h2, 32'h8);
    wr(4'h0, 32'h19);
    st();
    chk(o_ctl, 32'h13);
    rd(4'h0, 32'h19);
    rd(4'h5, 32'h13);
    rd(4'h7, 32'h0);
    wr(4'h2, 32'h0);
    wr(4'h0, 32'h10);
    st();
    chk(o_ctl, 32'h0);
    $display("ctl test done");
  endtask : t_ctl
  task automatic t_adv();
    logic [3:0] m [3] = '{4'h0, 4'h3, 4'h1};
    logic [15:0] e [3] = '{16'h31A0, 16'hDC01, 16'h4001};
    wr(4'h1, 32'hFFFF);
    for (int k = 0; k < 3; k++) begin
      wr(4'h2, {28'h0, m[k]});
      st();
      chk(o_advert_word, e[k]);
      chk(o_sgmii_mode, m[k][0]);
      rd(4'h6, {16'h0, e[k]});
    end
    $display("adv test done");
  endtask : t_adv
  // row: negotiation on, pins sync/done/xcvr, expected sync/link
  task automatic t_link();
    logic [7:0] tv [6] = '{8'hC2, 8'hE2, 8'hF3, 8'hB0, 8'hD2, 8'h53};
    wr(4'h2, 32'h8);
    wr(4'h3, 32'h8);
    foreach (tv[k]) begin
      wr(4'h0, {27'h0, tv[k][7], 4'h0});
      lvl <= tv[k][6:4];
      st();
      chk(o_stat, tv[k][1:0]);
      rd(4'h4, {30'h0, tv[k][1:0]});
    end
    $display("link test done");
  endtask : t_link
  task automatic t_pd();
    wr(4'h2, 32'h4);
    wr(4'h0, 32'h4);
    st();
    chk(o_ctl.xcvr_pdown, 1'b0);
    wr(4'h2, 32'h0);
    st();
    chk(o_ctl.xcvr_pdown, 1'b1);
    wr(4'h0, 32'h0);
    st();
    chk(o_ctl.xcvr_pdown, 1'b1);
    @(posedge i_clk_sys);
    i_arst_n <= 1'b0;
    st();
    @(posedge i_clk_sys);
    i_arst_n <= 1'b1;
    st();
    chk(o_ctl.xcvr_pdown, 1'b0);
    $display("pdown test done");
  endtask : t_pd
  task automatic final_report();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : final_report
  // main sequence
  initial begin
    repeat (8) @(posedge i_clk_sys);
    i_arst_n <= 1'b1;
    t_ctl();
    t_adv();
    t_link();
    t_pd();
    final_report();
  end
  // watchdog
  initial begin
    #100000;
    miscompares++;
    final_report();
  end
endmodule : pcsbc_bench
